// ===== inc/usp_pkg.sv
`default_nettype none
package usp_pkg;
   localparam int USP_NPARAM = 8;

   typedef logic [USP_NPARAM-1:0][31:0] usp_bank_t;

   typedef struct packed {
      usp_bank_t   stored;
      usp_bank_t   active;
      logic [31:0] rdata;
      logic        ack;
      logic        err;
   } usp_state_t;
endpackage
`default_nettype wire

// ===== inc/usp_regs.svh
// Overview of operation
// - Speed base exponent takes -3 to +3; reset value 0.
// - Position base exponent takes only 0, its reset value.
// - Acceleration base exponent takes 4 to 6; reset value 4.
// - Torque base exponent takes -5 to 0; reset value 0.
// - Capability word reads ones in bits 0 to 4 for speed units.
// - Capability word reads one in bit 8 for position reference units.
// - Capability word bit 16 reads one, bit 17 reads zero.
// - Capability word bit 24 reads zero, bits 25 and 26 read one.
// - Capability word reserved bits 5-7, 9-15, 18-23, 27-31 read zero.
`ifndef USP_REGS_SVH
`define USP_REGS_SVH

// ****************************************
// Parameter numbers
// ****************************************
`define USP_NUM_FIRST      8'h41
`define USP_NUM_LAST       8'h48
`define USP_NUM_CAP        8'h49

// ****************************************
// Accepted ranges, signed
// ****************************************
`define USP_SPD_UNIT_MIN   32'h0000_0000
`define USP_SPD_UNIT_MAX   32'h0000_0004
`define USP_SPD_EXP_MIN    32'hFFFF_FFFD
`define USP_SPD_EXP_MAX    32'h0000_0003
`define USP_POS_UNIT_MIN   32'h0000_0000
`define USP_POS_UNIT_MAX   32'h0000_0000
`define USP_POS_EXP_MIN    32'h0000_0000
`define USP_POS_EXP_MAX    32'h0000_0000
`define USP_ACC_UNIT_MIN   32'h0000_0000
`define USP_ACC_UNIT_MAX   32'h0000_0000
`define USP_ACC_EXP_MIN    32'h0000_0004
`define USP_ACC_EXP_MAX    32'h0000_0006
`define USP_TRQ_UNIT_MIN   32'h0000_0001
`define USP_TRQ_UNIT_MAX   32'h0000_0002
`define USP_TRQ_EXP_MIN    32'hFFFF_FFFB
`define USP_TRQ_EXP_MAX    32'h0000_0000

// ****************************************
// Reset values
// ****************************************
`define USP_SPD_UNIT_RST   32'h0000_0000
`define USP_SPD_EXP_RST    32'h0000_0000
`define USP_POS_UNIT_RST   32'h0000_0000
`define USP_POS_EXP_RST    32'h0000_0000
`define USP_ACC_UNIT_RST   32'h0000_0000
`define USP_ACC_EXP_RST    32'h0000_0004
`define USP_TRQ_UNIT_RST   32'h0000_0001
`define USP_TRQ_EXP_RST    32'h0000_0000

// ****************************************
// Capability word and its fields
// ****************************************
`define USP_CAP_WORD       32'h0601_011F
`define USP_CAP_SPD_MASK   32'h0000_001F
`define USP_CAP_POS_MASK   32'h0000_0100
`define USP_CAP_ACC_MASK   32'h0001_0000
`define USP_CAP_ACC_TIME   32'h0002_0000
`define USP_CAP_NM_MASK    32'h0100_0000
`define USP_CAP_TRQ_MASK   32'h0600_0000
`define USP_CAP_RSVD_MASK  32'hF8FC_FEE0

`endif

// ===== sim/usp_ctrl_model.sv
`default_nettype none
module usp_ctrl_model
(
   input  wire logic        sys_clk,
   input  wire logic        param_ack,
   input  wire logic        param_err,
   input  wire logic [31:0] param_rdata,
   output var  logic        param_req,
   output var  logic        param_we,
   output var  logic [7:0]  param_num,
   output var  logic [31:0] param_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      param_req = 1'b0;
      param_we = 1'b0;
      param_num = 8'h00;
      param_wdata = 32'h0000_0000;
   end
   // Only the bench picks the values, so out-of-range writes happen on its command
   task automatic access(input logic w, input logic [7:0] n, input logic [31:0] d,
                         output logic [31:0] q, output logic e, output logic a);
      @(posedge sys_clk);
      #1;
      param_req = 1'b1;
      param_we = w;
      param_num = n;
      param_wdata = d;
      @(posedge sys_clk);
      #1;
      param_req = 1'b0;
      // Idle data bus never keeps the last word, so a stale sample cannot pass
      param_wdata = ~d;
      a = param_ack;
      q = param_rdata;
      e = param_err;
   endtask
endmodule
`default_nettype wire

// ===== sim/usp_top_tb.sv
`default_nettype none
module usp_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Signals and tables
   // ****************************************
   logic        sys_clk, sys_rst, drive_restart;
   logic        param_req, param_we, param_ack, param_err;
   logic [7:0]  param_num;
   logic [31:0] param_wdata, param_rdata;
   logic [31:0] act [8];
   logic [31:0] sto [8];
   int          err_total, tests_run, cycles;
   localparam logic [31:0] DEF [8] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0004, 32'h0000_0001, 32'h0000_0000};
   localparam logic [40:0] TBL [20] = '{{8'h41, 32'h0000_0004, 1'b0},
      {8'h41, 32'h0000_0005, 1'b1}, {8'h42, 32'hFFFF_FFFD, 1'b0}, {8'h42, 32'hFFFF_FFFC, 1'b1},
      {8'h42, 32'h0000_0003, 1'b0}, {8'h42, 32'h0000_0004, 1'b1}, {8'h43, 32'h0000_0001, 1'b1},
      {8'h44, 32'h0000_0000, 1'b0}, {8'h44, 32'h0000_0001, 1'b1}, {8'h44, 32'hFFFF_FFFF, 1'b1},
      {8'h45, 32'h0000_0001, 1'b1}, {8'h46, 32'h0000_0006, 1'b0}, {8'h46, 32'h0000_0003, 1'b1},
      {8'h46, 32'h0000_0007, 1'b1}, {8'h47, 32'h0000_0002, 1'b0}, {8'h47, 32'h0000_0000, 1'b1},
      {8'h47, 32'h0000_0003, 1'b1}, {8'h48, 32'hFFFF_FFFB, 1'b0}, {8'h48, 32'hFFFF_FFFA, 1'b1},
      {8'h48, 32'h0000_0001, 1'b1}};
   usp_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .param_req(param_req),
      .param_we(param_we), .param_num(param_num), .param_wdata(param_wdata),
      .drive_restart(drive_restart), .param_rdata(param_rdata), .param_ack(param_ack),
      .param_err(param_err), .speed_unit_select(act[0]), .speed_base_exponent(act[1]),
      .position_unit_select(act[2]), .position_base_exponent(act[3]),
      .accel_unit_select(act[4]), .accel_base_exponent(act[5]),
      .torque_unit_select(act[6]), .torque_base_exponent(act[7]));
   usp_ctrl_model ctrl (.sys_clk(sys_clk), .param_ack(param_ack), .param_err(param_err),
      .param_rdata(param_rdata), .param_req(param_req), .param_we(param_we),
      .param_num(param_num), .param_wdata(param_wdata));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic complete_run();
      $display("counts: %0d checks, %0d mismatches", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] n, input logic [31:0] d,
                      input logic e, input logic [31:0] q);
      logic [31:0] rq;
      logic        re;
      logic        ra;
      ctrl.access(w, n, d, rq, re, ra);
      chk("ack", 32'h0000_0001, 32'(ra));
      chk("err", 32'(e), 32'(re));
      chk("rdata", q, rq);
   endtask
   task automatic chk_active(input logic [31:0] exp [8]);
      for (int i = 0; i < 8; i++)
         chk("active", exp[i], act[i]);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_defaults();
      for (int i = 0; i < 8; i++)
         acc(1'b0, 8'h41 + 8'(i), 32'h0000_0000, 1'b0, sto[i]);
      chk_active(DEF);
      $display("test defaults done");
   endtask
   task automatic t_cap();
      acc(1'b0, 8'h49, 32'h0000_0000, 1'b0, 32'h0601_011F);
      acc(1'b1, 8'h49, 32'hFFFF_FFFF, 1'b1, 32'h0601_011F);
      $display("test capability done");
   endtask
   task automatic t_range();
      int k;
      // A refused write must still read back the older stored value
      for (int i = 0; i < 20; i++)
      begin
         k = int'(TBL[i][40:33]) - 'h41;
         if (!TBL[i][0])
            sto[k] = TBL[i][32:1];
         acc(1'b1, TBL[i][40:33], TBL[i][32:1], TBL[i][0], sto[k]);
      end
      chk_active(DEF);
      $display("test ranges done");
   endtask
   task automatic t_restart();
      sto[5] = 32'h0000_0005;
      acc(1'b1, 8'h46, 32'h0000_0005, 1'b0, 32'h0000_0005);
      chk_active(DEF);
      @(posedge sys_clk);
      #1;
      drive_restart = 1'b1;
      @(posedge sys_clk);
      #1;
      drive_restart = 1'b0;
      chk_active(sto);
      acc(1'b0, 8'h40, 32'h0000_0000, 1'b1, 32'h0000_0000);
      acc(1'b1, 8'h4A, 32'h0000_0001, 1'b1, 32'h0000_0000);
      $display("test restart done");
   endtask
   // ****************************************
   // Clock, reset, timeout, main sequence
   // ****************************************
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cycles++;
      // Whole run needs under a hundred cycles; far beyond that means a hang
      if (cycles == 5000)
      begin
         err_total++;
         complete_run();
      end
   end
   initial
   begin
      sys_clk = 1'b0;
      sys_rst = 1'b1;
      drive_restart = 1'b0;
      err_total = 0;
      tests_run = 0;
      cycles = 0;
      sto = DEF;
      repeat (16) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      t_defaults();
      t_cap();
      t_range();
      t_restart();
      complete_run();
   end
endmodule
`default_nettype wire

// ===== src/usp_top.sv
`include "usp_regs.svh"
`default_nettype none
module usp_top
   import usp_pkg::*;
#(
   parameter int NUM_W = 8
)
(
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic             param_req,
   input  wire logic             param_we,
   input  wire logic [NUM_W-1:0] param_num,
   input  wire logic [31:0]      param_wdata,
   input  wire logic             drive_restart,
   output logic      [31:0]      param_rdata,
   output logic                  param_ack,
   output logic                  param_err,
   output logic      [31:0]      speed_unit_select,
   output logic      [31:0]      speed_base_exponent,
   output logic      [31:0]      position_unit_select,
   output logic      [31:0]      position_base_exponent,
   output logic      [31:0]      accel_unit_select,
   output logic      [31:0]      accel_base_exponent,
   output logic      [31:0]      torque_unit_select,
   output logic      [31:0]      torque_base_exponent
);

   // ****************************************
   // Tables
   // ****************************************
   localparam usp_bank_t MIN_TAB = {
      `USP_TRQ_EXP_MIN, `USP_TRQ_UNIT_MIN, `USP_ACC_EXP_MIN, `USP_ACC_UNIT_MIN,
      `USP_POS_EXP_MIN, `USP_POS_UNIT_MIN, `USP_SPD_EXP_MIN, `USP_SPD_UNIT_MIN};
   localparam usp_bank_t MAX_TAB = {
      `USP_TRQ_EXP_MAX, `USP_TRQ_UNIT_MAX, `USP_ACC_EXP_MAX, `USP_ACC_UNIT_MAX,
      `USP_POS_EXP_MAX, `USP_POS_UNIT_MAX, `USP_SPD_EXP_MAX, `USP_SPD_UNIT_MAX};
   localparam usp_bank_t RST_TAB = {
      `USP_TRQ_EXP_RST, `USP_TRQ_UNIT_RST, `USP_ACC_EXP_RST, `USP_ACC_UNIT_RST,
      `USP_POS_EXP_RST, `USP_POS_UNIT_RST, `USP_SPD_EXP_RST, `USP_SPD_UNIT_RST};

   generate
      if (NUM_W != 8)
      begin : g_num_w_check
         $error("usp_top: parameter numbers are eight bits wide");
      end
   endgenerate

   usp_state_t                cur;
   usp_state_t                next_cur;
   logic [USP_NPARAM-1:0]     in_range;
   logic                      hit_bank;
   logic                      hit_cap;
   logic [7:0]                idx_full;
   logic [2:0]                idx;

   // ****************************************
   // Range check per parameter
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < USP_NPARAM; g++)
      begin : g_rng
         // Signed compare, so negative exponents order below zero
         assign in_range[g] = ($signed(param_wdata) >= $signed(MIN_TAB[g])) &&
                              ($signed(param_wdata) <= $signed(MAX_TAB[g]));
      end
   endgenerate

   assign hit_bank = (param_num >= `USP_NUM_FIRST) && (param_num <= `USP_NUM_LAST);
   assign hit_cap  = (param_num == `USP_NUM_CAP);
   assign idx_full = 8'(param_num - `USP_NUM_FIRST);
   assign idx      = idx_full[2:0];

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      next_cur     = cur;
      next_cur.ack = 1'b0;
      next_cur.err = 1'b0;
      // Restart copies the stored bank; a write in the same cycle waits for the next one
      if (drive_restart)
      begin
         next_cur.active = cur.stored;
      end
      if (param_req)
      begin
         next_cur.ack = 1'b1;
         if (hit_bank)
         begin
            next_cur.rdata = cur.stored[idx];
            if (param_we)
            begin
               if (in_range[idx])
               begin
                  next_cur.stored[idx] = param_wdata;
                  next_cur.rdata       = param_wdata;
               end
               else
               begin
                  next_cur.err = 1'b1;
               end
            end
         end
         else if (hit_cap)
         begin
            next_cur.rdata = `USP_CAP_WORD;
            next_cur.err   = param_we;
         end
         else
         begin
            next_cur.rdata = 32'h0000_0000;
            next_cur.err   = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cur.stored <= RST_TAB;
         cur.active <= RST_TAB;
         cur.rdata  <= 32'h0000_0000;
         cur.ack    <= 1'b0;
         cur.err    <= 1'b0;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign param_rdata            = cur.rdata;
   assign param_ack              = cur.ack;
   assign param_err              = cur.err;
   // Motion logic sees only the active copy, never a half-applied setting
   assign speed_unit_select      = cur.active[0];
   assign speed_base_exponent    = cur.active[1];
   assign position_unit_select   = cur.active[2];
   assign position_base_exponent = cur.active[3];
   assign accel_unit_select      = cur.active[4];
   assign accel_base_exponent    = cur.active[5];
   assign torque_unit_select     = cur.active[6];
   assign torque_base_exponent   = cur.active[7];

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_cap_read;
      param_req && !param_we && hit_cap;
   endsequence

   sequence s_bad_write;
      param_req && param_we && hit_bank && !in_range[idx];
   endsequence

   sequence s_good_write;
      param_req && param_we && hit_bank && in_range[idx];
   endsequence

   sequence s_unmapped;
      param_req && !hit_bank && !hit_cap;
   endsequence

   spd_unit_range_a : assert property (
      $unsigned(cur.stored[0]) <= $unsigned(`USP_SPD_UNIT_MAX))
      else $error("speed unit select out of range");
   spd_exp_range_a : assert property (
      $signed(cur.stored[1]) >= $signed(`USP_SPD_EXP_MIN) &&
      $signed(cur.stored[1]) <= $signed(`USP_SPD_EXP_MAX))
      else $error("speed exponent out of range");
   pos_exp_zero_a : assert property (
      cur.stored[3] == 32'h0000_0000 && position_base_exponent == 32'h0000_0000)
      else $error("position exponent not zero");
   acc_exp_range_a : assert property (
      $signed(cur.stored[5]) >= $signed(`USP_ACC_EXP_MIN) &&
      $signed(cur.stored[5]) <= $signed(`USP_ACC_EXP_MAX))
      else $error("accel exponent out of range");
   trq_unit_code_a : assert property (
      cur.stored[6] == `USP_TRQ_UNIT_MIN || cur.stored[6] == `USP_TRQ_UNIT_MAX)
      else $error("torque unit code illegal");
   trq_exp_range_a : assert property (
      $signed(cur.stored[7]) >= $signed(`USP_TRQ_EXP_MIN) &&
      $signed(cur.stored[7]) <= $signed(`USP_TRQ_EXP_MAX))
      else $error("torque exponent out of range");
   cap_speed_bits_a : assert property (
      s_cap_read |=> param_ack && (param_rdata & `USP_CAP_SPD_MASK) == `USP_CAP_SPD_MASK)
      else $error("speed capability bits wrong");
   cap_pos_bit_a : assert property (
      s_cap_read |=> (param_rdata & `USP_CAP_POS_MASK) == `USP_CAP_POS_MASK)
      else $error("position capability bit wrong");
   cap_accel_bits_a : assert property (
      s_cap_read |=> (param_rdata & (`USP_CAP_ACC_MASK | `USP_CAP_ACC_TIME)) == `USP_CAP_ACC_MASK)
      else $error("accel capability bits wrong");
   cap_torque_bits_a : assert property (
      s_cap_read |=> (param_rdata & (`USP_CAP_NM_MASK | `USP_CAP_TRQ_MASK)) == `USP_CAP_TRQ_MASK)
      else $error("torque capability bits wrong");
   cap_reserved_a : assert property (
      s_cap_read |=> (param_rdata & `USP_CAP_RSVD_MASK) == 32'h0000_0000)
      else $error("capability reserved bits set");
   active_hold_a : assert property (
      !drive_restart |=> $stable(cur.active))
      else $error("active setting changed without restart");
   restart_apply_a : assert property (
      drive_restart |=> cur.active == $past(cur.stored))
      else $error("restart did not apply stored bank");
   bad_write_refused_a : assert property (
      s_bad_write |=> param_ack && param_err && cur.stored == $past(cur.stored))
      else $error("out of range write not refused");
   good_write_stored_a : assert property (
      s_good_write |=> cur.stored[$past(idx)] == $past(param_wdata) && !param_err)
      else $error("accepted write not stored");
   unmapped_refused_a : assert property (
      s_unmapped |=> param_ack && param_err && param_rdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   req_answer_a : assert property (
      param_req |=> param_ack)
      else $error("request not acknowledged");
   ack_quiet_a : assert property (
      !param_req |=> !param_ack && !param_err)
      else $error("answer without request");

endmodule
`default_nettype wire
